// ### testbench/rdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
  input wire logic clk_in,
  output logic ready_post_out,
  output logic large_block_read_out,
  output logic small_block_read_out,
  output logic raw_buffer_filled_out
);
  logic [3:0] ev = 4'h0;
  assign ready_post_out = ev[0];
  assign large_block_read_out = ev[1];
  assign small_block_read_out = ev[2];
  assign raw_buffer_filled_out = ev[3];

  // Back-to-back pulses, the densest event stream the engine can see
  task automatic burst(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      ev <= 4'h1 << sel;
    end
    @(posedge clk_in);
    ev <= 4'h0;
  endtask : burst
endmodule : rdc_host_model
`default_nettype wire

// ### testbench/rdc_rx_dma_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rdc_rx_dma_ctrl_bench;
  import rdc_pkg::*;
  typedef struct {logic [11:0] ctrl; int ev; int n; int fires;} rdc_row_t;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] be_n = 4'h0;
  logic [31:0] rdata, got;
  logic rvalid, accept, hwe, rpost, lread, sread, rawf, raw_post, rq_irq, lf_irq, sf_irq, flush;
  logic [2:0] lgrp, sgrp;
  logic [CHANNEL_W-1:0] flush_ch;
  int n_errors = 0, num_checks = 0, cyc = 0, flushes = 0, base = 0;
  int fires [4] = '{0, 0, 0, 0};
  // Each row ends on a whole number of thresholds, so counters start at zero
  rdc_row_t rows [21] = '{'{12'h000, 0, 4, 0}, '{12'h001, 0, 2, 2}, '{12'h021, 0, 8, 2},
    '{12'h041, 0, 12, 2}, '{12'h061, 0, 16, 2}, '{12'h081, 0, 32, 2}, '{12'h0A1, 0, 64, 2},
    '{12'h0C1, 0, 8, 0}, '{12'h0E1, 0, 8, 0}, '{12'h001, 1, 2, 2}, '{12'h101, 1, 8, 2},
    '{12'h201, 1, 16, 2}, '{12'h301, 1, 8, 0}, '{12'h001, 2, 2, 2}, '{12'h401, 2, 8, 2},
    '{12'h801, 2, 16, 2}, '{12'hC01, 2, 8, 0}, '{12'h001, 3, 2, 2}, '{12'h00B, 3, 4, 2},
    '{12'h015, 3, 6, 2}, '{12'h01F, 3, 8, 2}};

  always #12.5 clk_in = ~clk_in;

  rdc_rx_dma_ctrl #(.ACCESS_CYCLES(8)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .byte_enable_lines_n_in(be_n), .ready_post_in(rpost), .large_block_read_in(lread),
    .small_block_read_in(sread), .raw_buffer_filled_in(rawf), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .accept_data_out(accept), .host_write_enable_out(hwe),
    .large_fetch_group_out(lgrp), .small_fetch_group_out(sgrp), .raw_chain_post_out(raw_post),
    .ready_queue_interrupt_out(rq_irq), .large_free_queue_interrupt_out(lf_irq),
    .small_free_queue_interrupt_out(sf_irq), .flush_request_out(flush), .flush_channel_out(flush_ch));

  rdc_host_model pm (.clk_in(clk_in), .ready_post_out(rpost), .large_block_read_out(lread),
    .small_block_read_out(sread), .raw_buffer_filled_out(rawf));

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rq_irq === 1'b1) fires[0] <= fires[0] + 1;
    if (lf_irq === 1'b1) fires[1] <= fires[1] + 1;
    if (sf_irq === 1'b1) fires[2] <= fires[2] + 1;
    if (raw_post === 1'b1) fires[3] <= fires[3] + 1;
    if (flush === 1'b1) flushes <= flushes + 1;
  end

  always @(posedge clk_in) begin
    if (cyc == 20000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic chk_cnt(input int g, input int e, input string m);
    num_checks++;
    if (g != e) begin
      n_errors++;
      $display("[ERR] %0t %s: got %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_cnt

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    be_n <= b;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : reg_wr

  // Answer is registered on the taking edge and read 1 ns after it
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [3:0] b, output logic v);
    @(posedge clk_in);
    addr <= a;
    be_n <= b;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    got = rdata;
    v = rvalid;
  endtask : reg_rd

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [3:0] b, input logic ev,
                        input logic [31:0] ed);
    logic v;
    reg_rd(a, b, v);
    chk_val(v, ev, "read valid");
    chk_val(got, ed, "read data");
  endtask : rd_chk

  task automatic poll_busy;
    logic v;
    got = 32'h0000_8000;
    for (int i = 0; i < 20 && got[15] !== 1'b0; i++) reg_rd(PROVISION_OFFSET, 4'h0, v);
    chk_val(got[15], 1'b0, "busy stuck");
  endtask : poll_busy

  initial begin
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    foreach (rows[i]) begin
      reg_wr(CONTROL_OFFSET, {20'h0_0000, rows[i].ctrl}, 4'h0);
      rd_chk(CONTROL_OFFSET, 4'h0, 1'b1, {20'h0_0000, rows[i].ctrl});
      chk_val(accept, rows[i].ctrl[0], "accept");
      chk_val(hwe, rows[i].ctrl[0], "host write");
      chk_val(lgrp, rows[i].ctrl[1] ? FETCH_GROUP_CACHED : FETCH_GROUP_SINGLE, "large group");
      chk_val(sgrp, rows[i].ctrl[2] ? FETCH_GROUP_CACHED : FETCH_GROUP_SINGLE, "small group");
      base = fires[rows[i].ev];
      pm.burst(rows[i].ev, rows[i].n);
      repeat (3) @(posedge clk_in);
      chk_cnt(fires[rows[i].ev] - base, rows[i].fires, "fires");
    end
    base = flushes;
    reg_wr(PROVISION_OFFSET, 32'h0000_0005, 4'hE);
    reg_wr(PROVISION_OFFSET, 32'h0000_4007, 4'h0);
    rd_chk(PROVISION_OFFSET, 4'h0, 1'b1, 32'h0000_8005);
    poll_busy;
    chk_cnt(flushes - base, 1, "flush");
    chk_val(flush_ch, 7'h05, "flush channel");
    rd_chk(PROVISION_OFFSET, 4'h0, 1'b1, 32'h0000_0005);
    reg_wr(PROVISION_OFFSET, 32'h0000_4005, 4'h0);
    poll_busy;
    rd_chk(PROVISION_OFFSET, 4'h0, 1'b1, 32'h0000_4085);
    chk_cnt(flushes - base, 1, "query flush");
    reg_wr(CONTROL_OFFSET, 32'h0000_0000, ALL_LANES_NEGATED);
    rd_chk(CONTROL_OFFSET, ALL_LANES_NEGATED, 1'b0, 32'h0000_0000);
    rd_chk(CONTROL_OFFSET, 4'h0, 1'b1, 32'h0000_001F);
    reg_wr(12'h288, 32'hFFFF_FFFF, 4'h0);
    rd_chk(12'h288, 4'h0, 1'b1, 32'h0000_0000);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_chk(CONTROL_OFFSET, 4'h0, 1'b1, 32'h0000_001E);
    rd_chk(PROVISION_OFFSET, 4'h0, 1'b1, 32'h0000_0080);
    chk_val(lgrp, FETCH_GROUP_CACHED, "reset group");
    chk_val(accept, 1'b0, "reset accept");
    test_done;
  end
endmodule : rdc_rx_dma_ctrl_bench
`default_nettype wire

// ### verilog/rdc_event_counter.sv
`timescale 1ns/1ps
`default_nettype none
module rdc_event_counter #(
  parameter int CNT_W = 6
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic event_in,
  input wire logic [CNT_W-1:0] threshold_in,
  output logic fire_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] count_plus;
  logic armed;
  logic hit;
  logic [CNT_W-1:0] next_count;

  assign count_plus = count + 1'b1;
  assign armed = event_in && (threshold_in != '0);
  // Compare with >= so a lowered threshold cannot strand the count
  assign hit = armed && (count_plus >= threshold_in);
  assign next_count = hit ? '0 : (armed ? count_plus : count);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count <= '0;
      fire_out <= 1'b0;
    end else begin
      count <= next_count;
      fire_out <= hit;
    end
  end

  fire_cause_a: assert property (@(posedge clk_in) disable iff (!reset_n_in) // R5
    fire_out |-> $past(event_in) && ($past(threshold_in) != '0))
    else $error("Count output fired without a counted event");
endmodule : rdc_event_counter
`default_nettype wire

// ### verilog/rdc_pkg.sv
package rdc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 12'h280;
  localparam logic [ADDR_W-1:0] PROVISION_OFFSET = 12'h284;
  localparam logic [3:0] ALL_LANES_NEGATED = 4'hF;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LARGE_CACHE_BIT = 1;
  localparam int CTRL_SMALL_CACHE_BIT = 2;
  localparam int CTRL_RAW_LSB = 3;
  localparam int CTRL_RDY_LSB = 5;
  localparam int CTRL_LF_LSB = 8;
  localparam int CTRL_SF_LSB = 10;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h01E;

  // ----------------------------------------------------------------
  // Provisioning register fields
  // ----------------------------------------------------------------
  localparam int CHANNEL_W = 7;
  localparam int PROVISION_BIT = 7;
  localparam int READ_WRITE_BIT = 14;
  localparam int BUSY_BIT = 15;
  localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 7'h00;
  localparam logic PROVISION_RESET = 1'b1;
  localparam logic READ_WRITE_RESET = 1'b0;
  localparam int INDIRECT_ACCESS_CYCLES = 4;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [2:0] FETCH_GROUP_CACHED = 3'h6;
  localparam logic [2:0] FETCH_GROUP_SINGLE = 3'h1;

  typedef enum logic [1:0] {
    RDC_IDLE = 2'b01,
    RDC_ACCESS = 2'b10
  } rdc_state_t;

  // Zero means reserved code: the interrupt never fires
  function automatic logic [CNT_W-1:0] rdc_ready_threshold(input logic [2:0] code);
    unique case (code)
      3'h0: rdc_ready_threshold = 6'h01;
      3'h1: rdc_ready_threshold = 6'h04;
      3'h2: rdc_ready_threshold = 6'h06;
      3'h3: rdc_ready_threshold = 6'h08;
      3'h4: rdc_ready_threshold = 6'h10;
      3'h5: rdc_ready_threshold = 6'h20;
      default: rdc_ready_threshold = 6'h00;
    endcase
  endfunction : rdc_ready_threshold

  function automatic logic [CNT_W-1:0] rdc_free_threshold(input logic [1:0] code);
    unique case (code)
      2'h0: rdc_free_threshold = 6'h01;
      2'h1: rdc_free_threshold = 6'h04;
      2'h2: rdc_free_threshold = 6'h08;
      default: rdc_free_threshold = 6'h00;
    endcase
  endfunction : rdc_free_threshold
endpackage : rdc_pkg

// ### verilog/rdc_rx_dma_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Enable bit gates data acceptance and writes
// R2: Large cache bit: fetch six, else one
// R3: Small cache bit: fetch six, else one
// R4: Post raw chain every length-plus-one buffers
// R5: Ready interrupt after selected posting count
// R6: Large free interrupt after 4/8 reads
// R7: Large free code zero means one read
// R8: Small free interrupt after 1/4/8 reads
// R9: Unprovision transient: flush, then back provisioned
// R10: Provision writes ignore individual byte enables
// R11: All byte enables negated: no access
// R12: Channel field written; query loads memory value
// R13: Flag low unprovisions; next query reports high
// R14: Select bit: 0 provisions, 1 queries
// R15: Busy set on trigger until access done
// R16: Software polls busy before next use
// R17: Trigger writes ignored while busy
module rdc_rx_dma_ctrl #(
  parameter int ACCESS_CYCLES = rdc_pkg::INDIRECT_ACCESS_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [rdc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [3:0] byte_enable_lines_n_in,
  input wire logic ready_post_in,
  input wire logic large_block_read_in,
  input wire logic small_block_read_in,
  input wire logic raw_buffer_filled_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic accept_data_out,
  output logic host_write_enable_out,
  output logic [2:0] large_fetch_group_out,
  output logic [2:0] small_fetch_group_out,
  output logic raw_chain_post_out,
  output logic ready_queue_interrupt_out,
  output logic large_free_queue_interrupt_out,
  output logic small_free_queue_interrupt_out,
  output logic flush_request_out,
  output logic [rdc_pkg::CHANNEL_W-1:0] flush_channel_out
);
  import rdc_pkg::*;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] control;
  logic [CHANNEL_W-1:0] channel_select;
  logic provision_flag;
  logic read_write_select;
  logic busy;
  rdc_state_t state;
  logic [3:0] access_count;
  logic [CHANNEL_W-1:0] op_channel;
  logic op_provision;
  logic op_query;

  wire any_lane = byte_enable_lines_n_in != ALL_LANES_NEGATED;
  wire ctrl_hit = reg_addr_in == CONTROL_OFFSET;
  wire provision_hit = reg_addr_in == PROVISION_OFFSET;
  wire ctrl_write = reg_write_in && any_lane && ctrl_hit; // R11
  wire provision_write = reg_write_in && any_lane && provision_hit; // R11
  // Whole-register write while idle; writes during an access are dropped
  wire provision_trigger = provision_write && !busy; // R10 R17
  wire access_done = (state == RDC_ACCESS) && (access_count == 4'(ACCESS_CYCLES - 1));

  wire [31:0] ctrl_word = {20'h0_0000, control};
  wire [31:0] provision_word = {16'h0000, busy, read_write_select, 6'h00, provision_flag, channel_select};
  wire [31:0] next_rdata = ctrl_hit ? ctrl_word : (provision_hit ? provision_word : 32'h0000_0000);
  wire next_rvalid = reg_read_in && any_lane;

  // ----------------------------------------------------------------
  // Control register and configuration outputs
  // ----------------------------------------------------------------
  wire ctrl_enable = control[CTRL_ENABLE_BIT];
  wire [2:0] next_large_group = control[CTRL_LARGE_CACHE_BIT] ? FETCH_GROUP_CACHED : FETCH_GROUP_SINGLE; // R2
  wire [2:0] next_small_group = control[CTRL_SMALL_CACHE_BIT] ? FETCH_GROUP_CACHED : FETCH_GROUP_SINGLE; // R3
  wire [1:0] raw_len = control[CTRL_RAW_LSB +: 2];
  wire [CNT_W-1:0] raw_threshold = CNT_W'(raw_len) + 1'b1; // R4
  wire [CNT_W-1:0] ready_threshold = rdc_ready_threshold(control[CTRL_RDY_LSB +: 3]); // R5
  wire [CNT_W-1:0] large_threshold = rdc_free_threshold(control[CTRL_LF_LSB +: 2]); // R6 R7
  wire [CNT_W-1:0] small_threshold = rdc_free_threshold(control[CTRL_SF_LSB +: 2]); // R8

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      control <= CTRL_RESET;
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
      accept_data_out <= 1'b0;
      host_write_enable_out <= 1'b0;
      large_fetch_group_out <= FETCH_GROUP_CACHED;
      small_fetch_group_out <= FETCH_GROUP_CACHED;
    end else begin
      if (ctrl_write) begin
        control <= reg_wdata_in[CTRL_W-1:0];
      end
      reg_rdata_out <= next_rvalid ? next_rdata : 32'h0000_0000;
      reg_rvalid_out <= next_rvalid;
      accept_data_out <= ctrl_enable; // R1
      host_write_enable_out <= ctrl_enable; // R1
      large_fetch_group_out <= next_large_group;
      small_fetch_group_out <= next_small_group;
    end
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  // Disabled engine moves no data, so its events are not counted
  rdc_event_counter #(.CNT_W(CNT_W)) u_ready_count (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .event_in(ready_post_in && ctrl_enable), // R1 R5
    .threshold_in(ready_threshold), .fire_out(ready_queue_interrupt_out)
  );
  rdc_event_counter #(.CNT_W(CNT_W)) u_large_count (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .event_in(large_block_read_in && ctrl_enable), // R6
    .threshold_in(large_threshold), .fire_out(large_free_queue_interrupt_out)
  );
  rdc_event_counter #(.CNT_W(CNT_W)) u_small_count (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .event_in(small_block_read_in && ctrl_enable), // R8
    .threshold_in(small_threshold), .fire_out(small_free_queue_interrupt_out)
  );
  rdc_event_counter #(.CNT_W(CNT_W)) u_raw_count (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .event_in(raw_buffer_filled_in && ctrl_enable), // R4
    .threshold_in(raw_threshold), .fire_out(raw_chain_post_out)
  );

  // ----------------------------------------------------------------
  // Indirect provisioning access
  // ----------------------------------------------------------------
  // Unprovisioning only flushes the channel, so a query always reads the flag high
  wire next_flush = access_done && !op_query && !op_provision; // R9 R13 R14

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= RDC_IDLE;
      busy <= 1'b0;
      access_count <= 4'h0;
      channel_select <= CHANNEL_RESET;
      provision_flag <= PROVISION_RESET;
      read_write_select <= READ_WRITE_RESET;
      op_channel <= CHANNEL_RESET;
      op_provision <= PROVISION_RESET;
      op_query <= 1'b0;
      flush_request_out <= 1'b0;
      flush_channel_out <= CHANNEL_RESET;
    end else begin
      flush_request_out <= next_flush;
      unique case (state)
        RDC_IDLE: begin
          if (provision_trigger) begin
            channel_select <= reg_wdata_in[CHANNEL_W-1:0]; // R10 R12
            provision_flag <= reg_wdata_in[PROVISION_BIT];
            read_write_select <= reg_wdata_in[READ_WRITE_BIT];
            op_channel <= reg_wdata_in[CHANNEL_W-1:0];
            op_provision <= reg_wdata_in[PROVISION_BIT];
            op_query <= reg_wdata_in[READ_WRITE_BIT]; // R14
            busy <= 1'b1; // R15
            access_count <= 4'h0;
            state <= RDC_ACCESS;
          end
        end
        RDC_ACCESS: begin
          access_count <= access_count + 4'h1;
          if (access_done) begin
            busy <= 1'b0; // R15
            state <= RDC_IDLE;
            if (op_query) begin
              channel_select <= op_channel; // R12
              provision_flag <= 1'b1; // R13
            end else begin
              flush_channel_out <= op_channel; // R9
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  enable_gating_a: assert property (accept_data_out == $past(ctrl_enable) // R1
    && host_write_enable_out == accept_data_out)
    else $error("Data path enable does not follow the enable bit");
  large_group_a: assert property ((large_fetch_group_out == 3'h6) == $past(control[CTRL_LARGE_CACHE_BIT])) // R2
    else $error("Large fetch group size wrong");
  small_group_a: assert property ((small_fetch_group_out == 3'h6) == $past(control[CTRL_SMALL_CACHE_BIT])) // R3
    else $error("Small fetch group size wrong");
  // A running access may still end here, so only a new start is an error
  no_lane_access_a: assert property (reg_write_in && byte_enable_lines_n_in == ALL_LANES_NEGATED // R11
    |=> $stable(control) && !$rose(busy))
    else $error("Access made with all byte enables negated");
  no_lane_read_a: assert property (reg_read_in && byte_enable_lines_n_in == ALL_LANES_NEGATED // R11
    |=> !reg_rvalid_out)
    else $error("Read answered with all byte enables negated");
  read_answer_a: assert property (reg_read_in && byte_enable_lines_n_in != ALL_LANES_NEGATED // R11
    |=> reg_rvalid_out)
    else $error("Read not answered in the next cycle");
  full_word_write_a: assert property (provision_trigger |=> channel_select == $past(reg_wdata_in[6:0]) && busy) // R10 R15
    else $error("Provisioning write did not load all fields");
  trigger_fields_a: assert property (provision_trigger |=> op_query == $past(reg_wdata_in[READ_WRITE_BIT]) // R14
    && provision_flag == $past(reg_wdata_in[PROVISION_BIT]))
    else $error("Provisioning write did not load the select and flag");
  busy_bounded_a: assert property ($rose(busy) |-> ##[1:16] !busy) // R15
    else $error("Indirect access never completed");
  busy_ignore_a: assert property (busy && provision_write && !access_done // R17
    |=> $stable(read_write_select) && $stable(op_channel))
    else $error("Write during busy changed the access");
  unprov_flush_a: assert property (access_done && !op_query && !op_provision // R9 R13
    |=> flush_request_out && flush_channel_out == $past(op_channel))
    else $error("Unprovision did not flush the channel");
  no_flush_a: assert property (access_done && (op_query || op_provision) |=> !flush_request_out) // R13 R14
    else $error("Channel flushed without an unprovision");
  query_high_a: assert property (access_done && op_query |=> provision_flag && !busy) // R13 R14
    else $error("Query did not report the channel provisioned");
endmodule : rdc_rx_dma_ctrl
`default_nettype wire
